// ### spcl_regs.svh
// Opcodes, field positions, reset values and timing counts of the sector protection block
`ifndef SPCL_REGS_SVH
`define SPCL_REGS_SVH
`define SPCL_OP_RD_CFG     8'h2B
`define SPCL_OP_PG_CFG     8'h2F
`define SPCL_OP_RD_SEC     8'hFC
`define SPCL_OP_RD_SEC4    8'hE2
`define SPCL_OP_PG_SEC     8'hFD
`define SPCL_OP_PG_SEC4    8'hE3
`define SPCL_OP_ER_SEC     8'hE4
`define SPCL_OP_RD_PWD     8'hE7
`define SPCL_OP_PG_PWD     8'hE8
`define SPCL_OP_UNLOCK     8'hE9
`define SPCL_OP_RD_LOCK    8'hA7
`define SPCL_OP_CLR_LOCK   8'hA6
`define SPCL_OP_FREEZE     8'h91
`define SPCL_OP_CLR_ERR    8'h82
`define SPCL_OP_RD_STAT    8'h05
`define SPCL_MODE_NONE     2'h3
`define SPCL_MODE_PERSIST  2'h2
`define SPCL_MODE_PASSWORD 2'h1
`define SPCL_MODE_ILLEGAL  2'h0
`define SPCL_CFG_PLACE     15
`define SPCL_CFG_PWD       2
`define SPCL_CFG_PST       1
`define SPCL_STAT_WIP      0
`define SPCL_STAT_ERR      6
`define SPCL_PWD_RESET     64'hFFFFFFFFFFFFFFFF
`define SPCL_BYTE_ERASED   8'hFF
`define SPCL_BYTE_PROGRAM  8'h00
`define SPCL_BYTE_HIDDEN   8'hFF
`define SPCL_SECTORS       542
`define SPCL_BOT_OFS       10'h01E
`define SPCL_TOP_OFS       10'h1FE
`define SPCL_LEN_OP        4'h1
`define SPCL_LEN_CFG       4'h3
`define SPCL_LEN_PWD       4'h9
`define SPCL_ADDR3         4'h3
`define SPCL_ADDR4         4'h4
`define SPCL_LAST_BIT      3'h7
`define SPCL_SYNC_RESET    5'h01
`define SPCL_PROG_TIME_US  200
`define SPCL_CLK_MHZ       20
`define SPCL_PROG_CYCLES   (`SPCL_PROG_TIME_US * `SPCL_CLK_MHZ)
`endif

// ### spcl_pkg.sv
// Types shared by the sector protection block
package spcl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_SKIP  = 3'h4
  } spcl_state_t;
endpackage

// ### spcl_sector_protection.sv
// Protection mode configuration, password, lock register and sector bits behind a serial port
//
// How it works
// R01: Mode bits 11 means persistent mode by default
// R02: 10 persistent, 01 password, permanently chosen
// R03: Programming mode bits 00 aborts, sets error
// R04: Reprogramming chosen mode bits aborts, sets error
// R05: Config programming busy for page time, in-progress set
// R06: Placement bit programmable later while freeze clear
// R07: Parameter sectors top when 0, bottom when 1
// R08: Placement bit one-time: 0 never returns to 1
// R09: Password 64 bits, hidden once password mode
// R10: Global lock 0 blocks sector bits; clear command
// R11: Persistent mode: lock set at reset, sticky clear
// R12: Password mode: lock clear at reset, unlock sets
// R13: Freeze blocks placement bit changes
// R14: Freeze clears only by power or hardware reset
// R15: Sector byte 00h protected, FFh unprotected, erased default
// R16: Decode sector read, program, erase opcodes
// R17: Decode password read, program, unlock opcodes
// R18: Decode lock read, lock clear, freeze opcodes
// R19: Host programs password before selecting password mode
// R20: Host fixes placement before first array program
// R21: Host clears lock after sector bits configured
// R22: Sector protected if persistent or volatile bit zero
// R23: Unlock compares password, match sets global lock
// R24: Error flag sticky until clear command or reset
// R25: Password mismatch changes no protection state
`timescale 1ns/1ps
`include "spcl_regs.svh"

module spcl_sector_protection (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        csN,
  input  wire logic        sck,
  input  wire logic        mosi,
  output logic             miso_r,
  input  wire logic        hwReset,
  input  wire logic        swReset,
  input  wire logic [24:0] queryAddr,
  input  wire logic        volatileSectorBit,
  output logic             sectorProtected_r,
  output logic             writeInProgress_r,
  output logic             programError_r,
  output logic             globalLockBit_r,
  output logic             freezeBit_r,
  output logic             parameterPlacementBit_r,
  output logic [1:0]       modeLock_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {swReset, hwReset, mosi, sck, csN}
  logic [4:0] meta_r;
  logic [4:0] sync_r;
  logic       sckD_r, csD_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= `SPCL_SYNC_RESET;
      sync_r <= `SPCL_SYNC_RESET;
      sckD_r <= 1'b0;
      csD_r  <= 1'b1;
    end else begin
      meta_r <= {swReset, hwReset, mosi, sck, csN};
      sync_r <= meta_r;
      sckD_r <= sync_r[1];
      csD_r  <= sync_r[0];
    end
  end

  logic csLow, sckRise, sckFall, csRise, hwPulse, swPulse;
  assign csLow   = ~sync_r[0];
  assign sckRise = sync_r[1] & ~sckD_r;
  assign sckFall = ~sync_r[1] & sckD_r;
  assign csRise  = sync_r[0] & ~csD_r;
  assign hwPulse = sync_r[3];
  assign swPulse = sync_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // Address to sector index; two big blocks give way to 32 small sectors
  function automatic logic [9:0] secIdx(input logic [24:0] a, input logic place);
    logic [9:0] blk;
    blk = {1'b0, a[24:16]};
    if (place) begin // [R07]
      secIdx = (a[24:17] == 8'h00) ? {5'h00, a[16:12]} : blk + `SPCL_BOT_OFS;
    end else begin
      secIdx = (a[24:17] == 8'hFF) ? `SPCL_TOP_OFS + {5'h00, a[16:12]} : blk;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Command engine and protection state
  spcl_pkg::spcl_state_t state_r, state_nxt;
  logic [2:0]   bitCnt_r, bitCnt_nxt;
  logic [3:0]   byteCnt_r, byteCnt_nxt;
  logic [7:0]   rx_r, rx_nxt, tx_r, tx_nxt, opcode_r, opcode_nxt;
  logic [31:0]  addr_r, addr_nxt;
  logic [63:0]  data_r, data_nxt, pwd_r, pwd_nxt;
  logic [`SPCL_SECTORS-1:0] sectorBits_r, sectorBits_nxt;
  logic [11:0]  busyCnt_r, busyCnt_nxt;
  logic [1:0]   modeLock_nxt;
  logic         place_nxt, global_nxt, freeze_nxt, err_nxt, miso_nxt;
  logic         passwordMode, frameEnd, cfgBad, cfgCmd, unlockCmd, unlockHit, busyStart;
  logic [3:0]   addrLen, k;
  logic [15:0]  cfgData, cfgWord;
  logic [7:0]   rxNow, lockByte, statByte;
  logic [2:0]   pwdByte;

  assign passwordMode = (modeLock_r == `SPCL_MODE_PASSWORD); // [R02]
  assign frameEnd  = csRise && (state_r == spcl_pkg::ST_SHIFT) && (bitCnt_r == 3'h0);
  assign cfgData   = data_r[63:48];
  assign cfgCmd    = frameEnd && (opcode_r == `SPCL_OP_PG_CFG) && (byteCnt_r == `SPCL_LEN_CFG);
  // Illegal pair, or any change once a mode is fixed, aborts the whole write
  assign cfgBad    = (cfgData[2:1] == `SPCL_MODE_ILLEGAL) ||                  // [R03]
                     ((modeLock_r != `SPCL_MODE_NONE) && (cfgData[2:1] != modeLock_r)); // [R04]
  assign unlockCmd = frameEnd && (opcode_r == `SPCL_OP_UNLOCK) && (byteCnt_r == `SPCL_LEN_PWD);
  assign unlockHit = unlockCmd && passwordMode && (data_r == pwd_r); // [R23] [R25]
  assign lockByte  = {freezeBit_r, 6'h00, globalLockBit_r};
  assign statByte  = {1'b0, programError_r, 5'h00, writeInProgress_r};
  // Reserved config bits read as ones
  assign cfgWord   = {parameterPlacementBit_r, 12'hFFF, modeLock_r, 1'b1};

  always_comb begin
    state_nxt    = state_r;
    bitCnt_nxt   = bitCnt_r;
    byteCnt_nxt  = byteCnt_r;
    rx_nxt       = rx_r;
    tx_nxt       = tx_r;
    opcode_nxt   = opcode_r;
    addr_nxt     = addr_r;
    data_nxt     = data_r;
    pwd_nxt      = pwd_r;
    sectorBits_nxt = sectorBits_r;
    busyCnt_nxt  = (busyCnt_r != 12'h000) ? busyCnt_r - 12'h001 : busyCnt_r;
    modeLock_nxt = modeLock_r;
    place_nxt    = parameterPlacementBit_r;
    global_nxt   = globalLockBit_r;
    freeze_nxt   = freezeBit_r;
    err_nxt      = programError_r;
    miso_nxt     = miso_r;
    busyStart    = 1'b0;
    rxNow        = {rx_r[6:0], sync_r[2]};
    k            = 4'h0;
    pwdByte      = 3'h0;
    addrLen      = 4'h0;
    case (opcode_r)
      `SPCL_OP_RD_SEC, `SPCL_OP_PG_SEC:   addrLen = `SPCL_ADDR3;
      `SPCL_OP_RD_SEC4, `SPCL_OP_PG_SEC4: addrLen = `SPCL_ADDR4;
      default:                            addrLen = 4'h0;
    endcase
    // Clears first, so an error raised in the same cycle still wins
    if (swPulse || hwPulse) begin
      err_nxt = 1'b0; // [R24]
    end
    if (hwPulse) begin
      freeze_nxt = 1'b0; // [R14]
      global_nxt = ~passwordMode; // [R11] [R12]
    end
    if (!csLow) begin
      state_nxt   = spcl_pkg::ST_IDLE;
      bitCnt_nxt  = 3'h0;
      byteCnt_nxt = 4'h0;
    end else if (state_r == spcl_pkg::ST_IDLE) begin
      state_nxt = spcl_pkg::ST_SHIFT;
    end
    if (csLow && sckFall) begin
      miso_nxt = tx_r[7];
      tx_nxt   = {tx_r[6:0], 1'b0};
    end
    if (csLow && sckRise && (state_r != spcl_pkg::ST_IDLE)) begin
      rx_nxt     = rxNow;
      bitCnt_nxt = bitCnt_r + 3'h1;
      if (bitCnt_r == `SPCL_LAST_BIT && state_r == spcl_pkg::ST_SHIFT) begin
        if (byteCnt_r == 4'h0) begin
          opcode_nxt = rxNow;
          // Fresh address per frame, so a 3-byte address never inherits a bank bit
          addr_nxt   = 32'h00000000;
          // While busy every opcode but the status read ignores the bytes that follow it
          if (busyCnt_r != 12'h000 && rxNow != `SPCL_OP_RD_STAT) begin
            state_nxt = spcl_pkg::ST_SKIP;
          end
        end else if (byteCnt_r <= addrLen) begin
          addr_nxt = {addr_r[23:0], rxNow};
        end else begin
          data_nxt = {rxNow, data_r[63:8]};
        end
        if (byteCnt_r != 4'hF) begin
          byteCnt_nxt = byteCnt_r + 4'h1;
        end
        k       = byteCnt_nxt;
        pwdByte = 3'(k - 4'h1);
        case (opcode_nxt)
          `SPCL_OP_RD_STAT: tx_nxt = statByte;
          `SPCL_OP_RD_CFG:  tx_nxt = (k == 4'h1) ? cfgWord[7:0] : cfgWord[15:8];
          `SPCL_OP_RD_LOCK: tx_nxt = lockByte; // [R18]
          `SPCL_OP_RD_PWD:  tx_nxt = passwordMode ? `SPCL_BYTE_HIDDEN : pwd_r[8*pwdByte +: 8]; // [R17] [R09]
          `SPCL_OP_RD_SEC, `SPCL_OP_RD_SEC4: begin // [R16]
            tx_nxt = sectorBits_r[secIdx(addr_nxt[24:0], parameterPlacementBit_r)] ?
                     `SPCL_BYTE_ERASED : `SPCL_BYTE_PROGRAM; // [R15]
          end
          default:          tx_nxt = 8'h00;
        endcase
      end
    end
    if (frameEnd) begin
      case (opcode_r)
        `SPCL_OP_CLR_LOCK: if (byteCnt_r == `SPCL_LEN_OP) global_nxt = 1'b0; // [R18] [R10]
        `SPCL_OP_FREEZE:   if (byteCnt_r == `SPCL_LEN_OP) freeze_nxt = 1'b1; // [R18]
        `SPCL_OP_CLR_ERR: begin
          if (byteCnt_r == `SPCL_LEN_OP && !swPulse && !hwPulse) err_nxt = 1'b0; // [R24]
        end
        `SPCL_OP_ER_SEC: begin // [R16]
          if (byteCnt_r == `SPCL_LEN_OP && globalLockBit_r) begin // [R10]
            sectorBits_nxt = {`SPCL_SECTORS{1'b1}};
            busyStart      = 1'b1;
          end
        end
        `SPCL_OP_PG_SEC, `SPCL_OP_PG_SEC4: begin // [R16]
          if (byteCnt_r == addrLen + 4'h1 && globalLockBit_r) begin // [R10]
            sectorBits_nxt[secIdx(addr_r[24:0], parameterPlacementBit_r)] = 1'b0; // [R15]
            busyStart = 1'b1;
          end
        end
        `SPCL_OP_PG_PWD: begin // [R17]
          if (byteCnt_r == `SPCL_LEN_PWD && !passwordMode) begin
            pwd_nxt   = pwd_r & data_r; // [R09]
            busyStart = 1'b1;
          end
        end
        `SPCL_OP_UNLOCK: if (unlockHit) global_nxt = 1'b1; // [R17] [R12]
        `SPCL_OP_PG_CFG: begin
          if (cfgCmd && cfgBad) begin
            err_nxt = 1'b1; // [R03] [R04]
          end else if (cfgCmd) begin
            modeLock_nxt = modeLock_r & cfgData[2:1]; // [R02]
            // A one in the placement field never undoes a programmed zero
            if (!freezeBit_r && !cfgData[`SPCL_CFG_PLACE]) place_nxt = 1'b0; // [R06] [R08] [R13]
            busyStart = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (busyStart) begin
      busyCnt_nxt = 12'(`SPCL_PROG_CYCLES); // [R05]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r        <= spcl_pkg::ST_IDLE;
      bitCnt_r       <= 3'h0;
      byteCnt_r      <= 4'h0;
      rx_r           <= 8'h00;
      tx_r           <= 8'h00;
      opcode_r       <= 8'h00;
      addr_r         <= 32'h00000000;
      data_r         <= 64'h0000000000000000;
      pwd_r          <= `SPCL_PWD_RESET;
      sectorBits_r   <= {`SPCL_SECTORS{1'b1}};
      busyCnt_r      <= 12'h000;
      modeLock_r     <= `SPCL_MODE_NONE; // [R01]
      parameterPlacementBit_r <= 1'b1;
      globalLockBit_r <= 1'b1; // [R01] [R11]
      freezeBit_r    <= 1'b0;
      programError_r <= 1'b0;
      miso_r         <= 1'b0;
      writeInProgress_r <= 1'b0;
      sectorProtected_r <= 1'b0;
    end else begin
      state_r        <= state_nxt;
      bitCnt_r       <= bitCnt_nxt;
      byteCnt_r      <= byteCnt_nxt;
      rx_r           <= rx_nxt;
      tx_r           <= tx_nxt;
      opcode_r       <= opcode_nxt;
      addr_r         <= addr_nxt;
      data_r         <= data_nxt;
      pwd_r          <= pwd_nxt;
      sectorBits_r   <= sectorBits_nxt;
      busyCnt_r      <= busyCnt_nxt;
      modeLock_r     <= modeLock_nxt;
      parameterPlacementBit_r <= place_nxt;
      globalLockBit_r <= global_nxt;
      freezeBit_r    <= freeze_nxt;
      programError_r <= err_nxt;
      miso_r         <= miso_nxt;
      writeInProgress_r <= (busyCnt_nxt != 12'h000); // [R05]
      sectorProtected_r <= ~(sectorBits_r[secIdx(queryAddr, parameterPlacementBit_r)] &
                             volatileSectorBit); // [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_no_illegal_mode; modeLock_r != `SPCL_MODE_ILLEGAL; endproperty
  a_no_illegal_mode: assert property (p_no_illegal_mode) else $error("mode bits 00"); // [R03]
  property p_bad_cfg_flags;
    cfgCmd && cfgBad |=> programError_r && $stable(modeLock_r) && !writeInProgress_r;
  endproperty
  a_bad_cfg_flags: assert property (p_bad_cfg_flags) else $error("bad cfg kept"); // [R04]
  property p_mode_fixed; modeLock_r != `SPCL_MODE_NONE |=> $stable(modeLock_r); endproperty
  a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed"); // [R02]
  property p_busy_after_cfg; cfgCmd && !cfgBad |=> writeInProgress_r [*8]; endproperty
  a_busy_after_cfg: assert property (p_busy_after_cfg) else $error("no busy"); // [R05]
  property p_place_otp; !parameterPlacementBit_r |=> !parameterPlacementBit_r; endproperty
  a_place_otp: assert property (p_place_otp) else $error("placement back"); // [R08]
  property p_freeze_place; freezeBit_r |=> $stable(parameterPlacementBit_r); endproperty
  a_freeze_place: assert property (p_freeze_place) else $error("frozen change"); // [R13]
  property p_freeze_hold; freezeBit_r && !hwPulse |=> freezeBit_r; endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("freeze lost"); // [R14]
  property p_sectors_locked; !globalLockBit_r |=> $stable(sectorBits_r); endproperty
  a_sectors_locked: assert property (p_sectors_locked) else $error("locked change"); // [R10]
  property p_persist_sticky;
    !passwordMode && !globalLockBit_r && !hwPulse |=> !globalLockBit_r;
  endproperty
  a_persist_sticky: assert property (p_persist_sticky) else $error("lock set"); // [R11]
  property p_lock_rise;
    !hwPulse && !globalLockBit_r ##1 globalLockBit_r |-> passwordMode && $past(unlockHit);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock rose"); // [R12]
  property p_err_sticky;
    programError_r && !swPulse && !hwPulse && !(frameEnd && opcode_r == `SPCL_OP_CLR_ERR)
      |=> programError_r;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error dropped"); // [R24]

  c_unlock: cover property (unlockHit ##1 globalLockBit_r);
  c_freeze: cover property (frameEnd && opcode_r == `SPCL_OP_FREEZE ##1 freezeBit_r);
  c_cfg_err: cover property (cfgCmd && cfgBad);
  c_sec_prog: cover property (busyStart && opcode_r == `SPCL_OP_PG_SEC);

endmodule

// ### spcl_host_model.sv
// Host side serial controller model: frames commands and samples the reply line
`timescale 1ns/1ps

module spcl_host_model (
  input  wire logic clk,
  output logic      csN,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    csN  = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One whole frame, mode 0, four clk per phase (400 ns serial clock)
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    int         i;
    int         k;
    rx = {};
    b  = 8'h00;
    @(posedge clk) csN <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = 0; i < tx.size(); i++) begin
      for (k = 7; k >= 0; k--) begin
        mosi <= tx[i][k];
        repeat (4) @(posedge clk);
        sck  <= 1'b1;
        // Reply bit taken at the rising serial edge
        b[k] = miso;
        repeat (4) @(posedge clk);
        sck  <= 1'b0;
      end
      rx.push_back(b);
    end
    repeat (4) @(posedge clk);
    csN  <= 1'b1;
    // Serial clock stands still between frames; data line is toggled so it is never stale
    mosi <= ~mosi;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ### sector_protection_config_lock_tb_top.sv
// Self-checking bench for the sector protection block
`timescale 1ns/1ps

`define CHECK(what, exp, got) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
      errorCnt++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module sector_protection_config_lock_tb_top;
  logic        clk;
  logic        reset;
  logic        hwReset;
  logic        swReset;
  logic [24:0] queryAddr;
  logic        volatileSectorBit;
  logic        csN;
  logic        sck;
  logic        mosi;
  logic        miso;
  logic        sectorProt;
  logic        write_in_progress;
  logic        progErr;
  logic        lockBit;
  logic        freeze;
  logic        place;
  logic [1:0]  modeLock;
  logic [7:0]  rx[$];
  int          errorCnt;
  int          samplesChecked;
  localparam logic [63:0] PWD = 64'h0123456789ABCDEF;

  spcl_sector_protection dut (
    .clk                     (clk),
    .reset                   (reset),
    .csN                     (csN),
    .sck                     (sck),
    .mosi                    (mosi),
    .miso_r                  (miso),
    .hwReset                 (hwReset),
    .swReset                 (swReset),
    .queryAddr               (queryAddr),
    .volatileSectorBit       (volatileSectorBit),
    .sectorProtected_r       (sectorProt),
    .writeInProgress_r       (write_in_progress),
    .programError_r          (progErr),
    .globalLockBit_r         (lockBit),
    .freezeBit_r             (freeze),
    .parameterPlacementBit_r (place),
    .modeLock_r              (modeLock)
  );

  spcl_host_model host (
    .clk  (clk),
    .csN  (csN),
    .sck  (sck),
    .mosi (mosi),
    .miso (miso)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic closeOut;
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Busy time is fixed at 4000 clk, so the bound leaves margin
  task automatic waitIdle;
    int n;
    n = 0;
    tick(3);
    while (write_in_progress !== 1'b0 && n < 6000) begin
      tick(1);
      n++;
    end
    if (n >= 6000) begin
      errorCnt++;
      $display("ERROR busy wait expected 0 seen %0h", write_in_progress);
      closeOut();
    end
  endtask

  task automatic pinPulse(input bit hw);
    if (hw) hwReset <= 1'b1;
    else swReset <= 1'b1;
    tick(5);
    hwReset <= 1'b0;
    swReset <= 1'b0;
    tick(5);
  endtask

  task automatic cfgWrite(input logic [15:0] v);
    host.frame({8'h2F, v[7:0], v[15:8]}, rx);
    waitIdle();
  endtask

  task automatic query(input logic [24:0] a, input logic vol, input logic exp);
    queryAddr         <= a;
    volatileSectorBit <= vol;
    tick(3);
    `CHECK("sector protected", exp, sectorProt)
  endtask

  task automatic readSec(input logic [23:0] a, input logic [7:0] exp);
    host.frame({8'hFC, a[23:16], a[15:8], a[7:0], 8'h00}, rx);
    `CHECK("sector byte", exp, rx[4])
  endtask

  task automatic readPwd(input logic [63:0] exp);
    int i;
    host.frame({8'hE7, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, rx);
    for (i = 0; i < 8; i++) begin
      `CHECK("password byte", exp[8*i +: 8], rx[i+1])
    end
  endtask

  task automatic unlock(input logic [63:0] p);
    host.frame({8'hE9, p[7:0], p[15:8], p[23:16], p[31:24], p[39:32], p[47:40],
                p[55:48], p[63:56]}, rx);
    waitIdle();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic scReset;
    `CHECK("mode lock", 2'h3, modeLock)
    `CHECK("global lock", 1'b1, lockBit)
    `CHECK("freeze", 1'b0, freeze)
    `CHECK("placement", 1'b1, place)
    host.frame({8'hA7, 8'h00}, rx);
    `CHECK("lock register", 8'h01, rx[1])
    readSec(24'h000000, 8'hFF);
    query(25'h0000000, 1'b1, 1'b0);
  endtask

  task automatic scSector;
    host.frame({8'hFD, 8'h00, 8'h10, 8'h00}, rx);
    waitIdle();
    readSec(24'h001000, 8'h00);
    query(25'h0001FFF, 1'b1, 1'b1);
    query(25'h0000000, 1'b1, 1'b0);
    query(25'h0000000, 1'b0, 1'b1);
    host.frame({8'hE3, 8'h00, 8'h00, 8'h20, 8'h00}, rx);
    waitIdle();
    host.frame({8'hE2, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00}, rx);
    `CHECK("wide sector byte", 8'h00, rx[5])
    host.frame({8'hE4}, rx);
    waitIdle();
    readSec(24'h001000, 8'hFF);
  endtask

  task automatic scLock;
    host.frame({8'hA6}, rx);
    tick(2);
    `CHECK("lock after clear", 1'b0, lockBit)
    host.frame({8'hFD, 8'h00, 8'h30, 8'h00}, rx);
    waitIdle();
    readSec(24'h003000, 8'hFF);
    `CHECK("no error on locked program", 1'b0, progErr)
    pinPulse(1'b1);
    `CHECK("lock after hw reset", 1'b1, lockBit)
  endtask

  task automatic scFreeze;
    host.frame({8'h91}, rx);
    tick(2);
    `CHECK("freeze set", 1'b1, freeze)
    host.frame({8'hA7, 8'h00}, rx);
    `CHECK("lock register frozen", 8'h81, rx[1])
    cfgWrite(16'h7FFF);
    `CHECK("placement frozen", 1'b1, place)
    pinPulse(1'b0);
    `CHECK("freeze after sw reset", 1'b1, freeze)
    pinPulse(1'b1);
    `CHECK("freeze after hw reset", 1'b0, freeze)
  endtask

  task automatic scMode;
    cfgWrite(16'hFFF9);
    `CHECK("error on both bits", 1'b1, progErr)
    `CHECK("mode kept", 2'h3, modeLock)
    host.frame({8'hA7, 8'h00}, rx);
    `CHECK("error sticky", 1'b1, progErr)
    host.frame({8'h82}, rx);
    tick(2);
    `CHECK("error cleared", 1'b0, progErr)
    host.frame({8'hE8, PWD[7:0], PWD[15:8], PWD[23:16], PWD[31:24], PWD[39:32],
                PWD[47:40], PWD[55:48], PWD[63:56]}, rx);
    waitIdle();
    readPwd(PWD);
    host.frame({8'h2F, 8'hFB, 8'hFF}, rx);
    tick(3);
    `CHECK("busy during config", 1'b1, write_in_progress)
    host.frame({8'h05, 8'h00}, rx);
    `CHECK("status busy bit", 1'b1, rx[1][0])
    waitIdle();
    `CHECK("password mode", 2'h1, modeLock)
    cfgWrite(16'hFFFD);
    `CHECK("error on mode change", 1'b1, progErr)
    `CHECK("mode fixed", 2'h1, modeLock)
    pinPulse(1'b0);
    `CHECK("error after sw reset", 1'b0, progErr)
    readPwd(64'hFFFFFFFFFFFFFFFF);
    pinPulse(1'b1);
    `CHECK("lock in password mode", 1'b0, lockBit)
    unlock(~PWD);
    `CHECK("lock after bad unlock", 1'b0, lockBit)
    `CHECK("mode after bad unlock", 2'h1, modeLock)
    unlock(PWD);
    `CHECK("lock after unlock", 1'b1, lockBit)
  endtask

  task automatic scPlace;
    cfgWrite(16'h7FFB);
    `CHECK("placement to top", 1'b0, place)
    cfgWrite(16'hFFFB);
    `CHECK("placement one-time", 1'b0, place)
    host.frame({8'h2B, 8'h00, 8'h00}, rx);
    `CHECK("config low byte", 8'hFB, rx[1])
    `CHECK("config high byte", 8'h7F, rx[2])
    host.frame({8'hE3, 8'h01, 8'hFF, 8'hF0, 8'h00}, rx);
    waitIdle();
    query(25'h1FFF000, 1'b1, 1'b1);
    query(25'h1FFE000, 1'b1, 1'b0);
  endtask

  initial begin
    errorCnt          = 0;
    samplesChecked    = 0;
    reset             = 1'b1;
    hwReset           = 1'b0;
    swReset           = 1'b0;
    queryAddr         = 25'h0000000;
    volatileSectorBit = 1'b1;
    tick(8);
    reset <= 1'b0;
    tick(4);
    scReset();
    scSector();
    scLock();
    scFreeze();
    scMode();
    scPlace();
    closeOut();
  end
endmodule
